// [rtl/iets_pkg.sv]
`default_nettype none
package iets_pkg;
    // request nodes
    localparam int NODES      = 96;
    localparam int NODE_W     = 7;
    localparam int LVL_W      = 4;
    // event transfer channels
    localparam int CHANS      = 8;
    localparam int CH_W       = 3;
    localparam int PTR_W      = 24;
    localparam int CNT_W      = 8;
    // traps: six hardware sources plus the two system requests
    localparam int TRAPS      = 8;
    localparam int HW_TRAPS   = 6;
    localparam int ESR_PINS   = 3;
    // external request router
    localparam int RTR_CH     = 4;
    // nodes that a router output may take over
    localparam int SHARED_BASE = 88;
    // request-to-service latency in cpu clocks
    localparam int LAT_JC_CLK  = 7;
    localparam int LAT_NJC_CLK = 11;
    localparam logic [3:0] LAT_JC_INIT  = 4'(LAT_JC_CLK - 2);
    localparam logic [3:0] LAT_NJC_INIT = 4'(LAT_NJC_CLK - 2);
    // reset values
    localparam logic [NODES-1:0] FLAG_RST = '0;
    localparam logic [TRAPS-1:0] TRAP_RST = '0;
    localparam logic [LVL_W-1:0] TRAP_LVL = 4'hF;

    typedef logic [NODE_W-1:0] iets_node_t;
    typedef logic [LVL_W-1:0]  iets_lvl_t;
    typedef logic [CH_W-1:0]   iets_ch_t;
    typedef logic [PTR_W-1:0]  iets_ptr_t;
    typedef logic [CNT_W-1:0]  iets_cnt_t;

    typedef enum logic [1:0] {
        SVC_IRQ    = 2'h0,
        SVC_TRAP   = 2'h1,
        SVC_SWTRAP = 2'h2
    } iets_svc_t;

    // gray along idle -> wait -> idle; xfer is a side branch
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_XFER = 2'h2
    } iets_state_t;
endpackage
`default_nettype wire

// [rtl/iets_router.sv]
`timescale 1ns/1ps
`default_nettype none
module iets_router (
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset,
    // levels in, gated events out
    iets_rtr_if.rtr     rif
);
    localparam int N = iets_pkg::RTR_CH;

    logic [N-1:0] prev_q;
    logic [N-1:0] det;
    logic [N-1:0] evt_q;

    // previous level for edge detection; inputs arrive already synchronised
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            prev_q <= '0;
        else
            prev_q <= rif.lvl;
    end

    genvar k;
    generate
        for (k = 0; k < N; k++)
        begin : g_ch
            logic hit;
            logic match;
            // 01 rising, 10 falling, 11 both
            assign det[k] = (rif.edge_sel[2*k] & rif.lvl[k] & ~prev_q[k])
                          | (rif.edge_sel[2*k+1] & ~rif.lvl[k] & prev_q[k]); // see R12
            // output unit k takes every input its route bits select
            assign hit   = |(det & rif.route[k*N +: N]);
            // pattern only covers the routed inputs
            assign match = ((rif.lvl ^ rif.pat[k*N +: N])
                           & rif.route[k*N +: N]) == '0;
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    evt_q[k] <= 1'b0;
                else
                begin
                    case (rif.gate[2*k +: 2])                   // see R13
                        2'h0:    evt_q[k] <= 1'b0;
                        2'h1:    evt_q[k] <= hit;
                        2'h2:    evt_q[k] <= hit & match;
                        default: evt_q[k] <= hit & ~match;
                    endcase
                end
            end
        end
    endgenerate

    assign rif.evt = evt_q;
endmodule
`default_nettype wire

// [rtl/iets_rtr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface iets_rtr_if;
    logic [iets_pkg::RTR_CH-1:0]   lvl;
    logic [2*iets_pkg::RTR_CH-1:0] edge_sel;
    logic [iets_pkg::RTR_CH*iets_pkg::RTR_CH-1:0] route;
    logic [iets_pkg::RTR_CH*iets_pkg::RTR_CH-1:0] pat;
    logic [2*iets_pkg::RTR_CH-1:0] gate;
    logic [iets_pkg::RTR_CH-1:0]   evt;

    modport rtr (input lvl, edge_sel, route, pat, gate, output evt);
    modport top (output lvl, edge_sel, route, pat, gate, input evt);
endinterface
`default_nettype wire

// [rtl/iets_top.sv]
// Contract
// R1 - each node goes to vector or channel
// R2 - standard service branches to node vector
// R3 - channel service steals exactly one cycle
// R4 - channel moves byte/word, bumps chosen pointers
// R5 - counter decrements unless continuous mode
// R6 - counter at zero raises standard interrupt
// R7 - eight independent event transfer channels
// R8 - service starts 7 or 11 clocks later
// R9 - 96 nodes with flag, enable, priority
// R10 - shared nodes pick source by selection
// R11 - router: four inputs, matrix, four gates
// R12 - router detects rising, falling or both
// R13 - gate passes on pattern match or miss
// R14 - hardware trap branches to trap vector
// R15 - each trap sets its own flag bit
// R16 - trap preempts unless higher trap active
// R17 - no interrupts during trap service
// R18 - three pins feed two system requests
// R19 - software trap starts numbered routine
// R20 - software flag write acts like hardware
// R21 - grant highest enabled priority above cpu
`timescale 1ns/1ps
`default_nettype none
module iets_top (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // cpu side
    input  wire iets_pkg::iets_lvl_t         cpu_level,
    input  wire logic                        jump_cache_en,
    input  wire logic                        trap_done,
    input  wire logic                        sw_trap,
    input  wire iets_pkg::iets_node_t        sw_trap_num,
    // request nodes
    input  wire logic [iets_pkg::NODES-1:0]  periph_req,
    input  wire logic [iets_pkg::NODES-1:0]  node_sw_set,
    input  wire logic [iets_pkg::NODES-1:0]  node_sw_clr,
    input  wire logic [iets_pkg::NODES-1:0]  node_en,
    input  wire logic [iets_pkg::NODES*iets_pkg::LVL_W-1:0] node_prio,
    input  wire logic [iets_pkg::NODES-1:0]  node_etc_en,
    input  wire logic [iets_pkg::NODES*iets_pkg::CH_W-1:0]  node_chan,
    input  wire logic [iets_pkg::RTR_CH-1:0] src_sel,
    // event transfer channel setup
    input  wire logic [iets_pkg::CHANS-1:0]  ch_load,
    input  wire iets_pkg::iets_ptr_t         ch_load_src,
    input  wire iets_pkg::iets_ptr_t         ch_load_dst,
    input  wire iets_pkg::iets_cnt_t         ch_load_cnt,
    input  wire logic [iets_pkg::CHANS-1:0]  ch_word,
    input  wire logic [iets_pkg::CHANS-1:0]  ch_inc_src,
    input  wire logic [iets_pkg::CHANS-1:0]  ch_inc_dst,
    input  wire logic [iets_pkg::CHANS-1:0]  ch_cont,
    // external request router
    input  wire logic [iets_pkg::RTR_CH-1:0]   rtr_pin,
    input  wire logic [2*iets_pkg::RTR_CH-1:0] rtr_edge_sel,
    input  wire logic [iets_pkg::RTR_CH*iets_pkg::RTR_CH-1:0] rtr_route,
    input  wire logic [iets_pkg::RTR_CH*iets_pkg::RTR_CH-1:0] rtr_pat,
    input  wire logic [2*iets_pkg::RTR_CH-1:0] rtr_gate,
    // service request pins
    input  wire logic [iets_pkg::ESR_PINS-1:0] esr_pin,
    input  wire logic [iets_pkg::ESR_PINS-1:0] esr_en,
    input  wire logic [iets_pkg::ESR_PINS-1:0] esr_map,
    // hardware traps
    input  wire logic [iets_pkg::HW_TRAPS-1:0] hw_trap,
    input  wire logic [iets_pkg::TRAPS-1:0]    trap_flag_clr,
    // service start towards the cpu
    output logic                             svc_start,
    output iets_pkg::iets_svc_t              svc_kind,
    output iets_pkg::iets_node_t             svc_num,
    output iets_pkg::iets_lvl_t              svc_level,
    // stolen transfer cycle
    output logic                             xfer_valid,
    output iets_pkg::iets_ch_t               xfer_chan,
    output iets_pkg::iets_ptr_t              xfer_src,
    output iets_pkg::iets_ptr_t              xfer_dst,
    output logic                             xfer_word,
    // status
    output logic [iets_pkg::NODES-1:0]       node_flag,
    output logic [iets_pkg::TRAPS-1:0]       trap_flag,
    output logic [iets_pkg::TRAPS-1:0]       trap_active
);
    localparam int NODES = iets_pkg::NODES;
    localparam int TRAPS = iets_pkg::TRAPS;
    localparam int CHANS = iets_pkg::CHANS;
    localparam int RC    = iets_pkg::RTR_CH;
    localparam int NE    = iets_pkg::ESR_PINS;

    iets_rtr_if rif ();

    // pin synchronisers, stage one read only by stage two;
    // no reset: the pins settle while reset is held
    logic [RC-1:0] rtr_s1_q, rtr_s2_q;
    logic [NE-1:0] esr_s1_q, esr_s2_q, esr_prev_q;
    always_ff @(posedge clk_sys)
    begin
        rtr_s1_q   <= rtr_pin;
        rtr_s2_q   <= rtr_s1_q;
        esr_s1_q   <= esr_pin;
        esr_s2_q   <= esr_s1_q;
        esr_prev_q <= esr_s2_q;
    end

    // router config travels with the synced levels
    assign rif.lvl      = rtr_s2_q;
    assign rif.edge_sel = rtr_edge_sel;
    assign rif.route    = rtr_route;
    assign rif.pat      = rtr_pat;
    assign rif.gate     = rtr_gate;

    iets_router u_router (                                    // see R11
        .clk_sys (clk_sys),
        .reset   (reset),
        .rif     (rif)
    );

    // node sources: shared nodes may take a router output instead
    logic [NODES-1:0] src_req;
    always_comb
    begin
        src_req = periph_req;
        for (int k = 0; k < RC; k++)
            if (src_sel[k])
                src_req[iets_pkg::SHARED_BASE + k] = rif.evt[k]; // see R10
    end

    // system requests from rising edges on enabled pins
    logic [NE-1:0] esr_rise;
    logic          sreq_zero, sreq_one;
    logic [TRAPS-1:0] trap_evt;
    assign esr_rise  = esr_s2_q & ~esr_prev_q & esr_en;
    assign sreq_zero = |(esr_rise & ~esr_map);                  // see R18
    assign sreq_one  = |(esr_rise & esr_map);                   // see R18
    assign trap_evt  = {sreq_one, sreq_zero, hw_trap};

    // state
    iets_pkg::iets_state_t st_q;
    logic [NODES-1:0]      flag_q, flag_d;
    logic [TRAPS-1:0]      tflag_q, tpend_q, tact_q;
    logic [3:0]            lat_q;
    iets_pkg::iets_node_t  wait_idx_q;
    iets_pkg::iets_lvl_t   wait_lvl_q;
    logic                  sw_pend_q;
    iets_pkg::iets_node_t  sw_num_q;
    iets_pkg::iets_ptr_t   src_q [CHANS];
    iets_pkg::iets_ptr_t   dst_q [CHANS];
    iets_pkg::iets_cnt_t   cnt_q [CHANS];

    // arbitration: strict greater-than keeps the lowest index on ties
    logic                 win_found, win_etc;
    iets_pkg::iets_node_t win_idx;
    iets_pkg::iets_lvl_t  win_lvl;
    iets_pkg::iets_ch_t   win_chan;
    always_comb
    begin
        win_found = 1'b0;
        win_etc   = 1'b0;
        win_idx   = '0;
        win_lvl   = cpu_level;
        win_chan  = '0;
        for (int i = 0; i < NODES; i++)
        begin
            if (flag_q[i] && node_en[i] &&
                node_prio[i*iets_pkg::LVL_W +: iets_pkg::LVL_W] > win_lvl)
            begin                                               // see R21
                win_found = 1'b1;
                win_idx   = iets_pkg::iets_node_t'(i);
                win_lvl   = node_prio[i*iets_pkg::LVL_W +: iets_pkg::LVL_W];
                win_chan  = node_chan[i*iets_pkg::CH_W +: iets_pkg::CH_W];
                win_etc   = node_etc_en[i];                     // see R1
            end
        end
    end

    // a spent, non-continuous channel hands its node to the vector path
    logic use_etc, last_xfer;
    assign use_etc   = win_etc && (cnt_q[win_chan] != '0 || ch_cont[win_chan]);
    assign last_xfer = !ch_cont[win_chan] &&
                       cnt_q[win_chan] == iets_pkg::iets_cnt_t'(1);

    // trap priority: lower index ranks higher
    logic [3:0] tp_idx, ta_idx;
    always_comb
    begin
        tp_idx = 4'(TRAPS);
        ta_idx = 4'(TRAPS);
        for (int t = TRAPS - 1; t >= 0; t--)
        begin
            if (tpend_q[t])
                tp_idx = 4'(t);
            if (tact_q[t])
                ta_idx = 4'(t);
        end
    end

    logic take_trap, take_sw, take_node, fire_irq, fire_xfer;
    assign take_trap = tp_idx < ta_idx;                         // see R16
    assign take_sw   = !take_trap && sw_pend_q;
    // nodes stay out while any trap routine runs
    assign take_node = !take_trap && !sw_pend_q && tact_q == '0 &&
                       win_found;                               // see R17
    assign fire_xfer = st_q == iets_pkg::ST_IDLE && take_node && use_etc;
    assign fire_irq  = st_q == iets_pkg::ST_WAIT && !take_trap &&
                       lat_q == 4'h0;

    // sequencer
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_q       <= iets_pkg::ST_IDLE;
            lat_q      <= 4'h0;
            wait_idx_q <= '0;
            wait_lvl_q <= '0;
        end
        else
        begin
            case (st_q)
                iets_pkg::ST_IDLE:
                begin
                    if (take_node && !use_etc)
                    begin
                        st_q       <= iets_pkg::ST_WAIT;
                        lat_q      <= jump_cache_en ? iets_pkg::LAT_JC_INIT
                                                    : iets_pkg::LAT_NJC_INIT;
                        wait_idx_q <= win_idx;                  // see R8
                        wait_lvl_q <= win_lvl;
                    end
                    else if (fire_xfer)
                        st_q <= iets_pkg::ST_XFER;
                end
                iets_pkg::ST_WAIT:
                begin
                    // a trap aborts the wait; the node flag stays set
                    if (take_trap || lat_q == 4'h0)
                        st_q <= iets_pkg::ST_IDLE;
                    else
                        lat_q <= lat_q - 4'h1;                  // see R8
                end
                iets_pkg::ST_XFER:
                    st_q <= iets_pkg::ST_IDLE;                  // see R3
                default:
                    st_q <= iets_pkg::ST_IDLE;
            endcase
        end
    end
    // service start pulse; traps win the idle slot
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            svc_start <= 1'b0;
            svc_kind  <= iets_pkg::SVC_IRQ;
            svc_num   <= '0;
            svc_level <= '0;
        end
        else
        begin
            svc_start <= 1'b0;
            if (st_q != iets_pkg::ST_XFER && take_trap)
            begin
                svc_start <= 1'b1;                              // see R14
                svc_kind  <= iets_pkg::SVC_TRAP;
                svc_num   <= iets_pkg::iets_node_t'(tp_idx);
                svc_level <= iets_pkg::TRAP_LVL;
            end
            else if (st_q == iets_pkg::ST_IDLE && take_sw)
            begin
                svc_start <= 1'b1;                              // see R19
                svc_kind  <= iets_pkg::SVC_SWTRAP;
                svc_num   <= sw_num_q;
                svc_level <= cpu_level;
            end
            else if (fire_irq)
            begin
                svc_start <= 1'b1;                              // see R2
                svc_kind  <= iets_pkg::SVC_IRQ;
                svc_num   <= wait_idx_q;
                svc_level <= wait_lvl_q;
            end
        end
    end

    // node flags: any set beats any clear in the same cycle
    always_comb
    begin
        flag_d = flag_q;
        if (fire_irq)
            flag_d[wait_idx_q] = 1'b0;
        if (fire_xfer && !last_xfer)
            flag_d[win_idx] = 1'b0;                             // see R6
        flag_d = (flag_d & ~node_sw_clr) | src_req | node_sw_set; // see R20
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            flag_q <= iets_pkg::FLAG_RST;                       // see R9
        else
            flag_q <= flag_d;
    end

    // trap flags, pending and active masks
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tflag_q <= iets_pkg::TRAP_RST;
            tpend_q <= iets_pkg::TRAP_RST;
            tact_q  <= iets_pkg::TRAP_RST;
        end
        else
        begin
            tflag_q <= (tflag_q & ~trap_flag_clr) | trap_evt;   // see R15
            if (st_q != iets_pkg::ST_XFER && take_trap)
            begin
                tpend_q <= (tpend_q & ~(8'h01 << tp_idx)) | trap_evt;
                tact_q  <= tact_q | (8'h01 << tp_idx);
            end
            else
            begin
                tpend_q <= tpend_q | trap_evt;
                // return ends the innermost, highest ranked trap
                if (trap_done && ta_idx < 4'(TRAPS))
                    tact_q <= tact_q & ~(8'h01 << ta_idx);
            end
        end
    end

    // software trap request is held until the idle slot
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sw_pend_q <= 1'b0;
            sw_num_q  <= '0;
        end
        else if (sw_trap)
        begin
            sw_pend_q <= 1'b1;
            sw_num_q  <= sw_trap_num;
        end
        else if (st_q == iets_pkg::ST_IDLE && take_sw)
            sw_pend_q <= 1'b0;
    end

    // channel pointers and counters; a load overrides a service
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            for (int c = 0; c < CHANS; c++)
            begin                                               // see R7
                src_q[c] <= '0;
                dst_q[c] <= '0;
                cnt_q[c] <= '0;
            end
        end
        else
        begin
            for (int c = 0; c < CHANS; c++)
            begin
                if (ch_load[c])
                begin
                    src_q[c] <= ch_load_src;
                    dst_q[c] <= ch_load_dst;
                    cnt_q[c] <= ch_load_cnt;
                end
                else if (fire_xfer && win_chan == iets_pkg::iets_ch_t'(c))
                begin
                    if (ch_inc_src[c])                          // see R4
                        src_q[c] <= src_q[c] + (ch_word[c] ? 24'h2 : 24'h1);
                    if (ch_inc_dst[c])
                        dst_q[c] <= dst_q[c] + (ch_word[c] ? 24'h2 : 24'h1);
                    if (!ch_cont[c])
                        cnt_q[c] <= cnt_q[c] - 8'h01;           // see R5
                end
            end
        end
    end
    // one stolen bus cycle per service, addresses before the bump
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            xfer_valid <= 1'b0;
            xfer_word  <= 1'b0;
            xfer_chan  <= '0;
            xfer_src   <= '0;
            xfer_dst   <= '0;
        end
        else
        begin
            xfer_valid <= fire_xfer;                            // see R3
            if (fire_xfer)
            begin
                xfer_word <= ch_word[win_chan];                 // see R4
                xfer_chan <= win_chan;
                xfer_src  <= src_q[win_chan];
                xfer_dst  <= dst_q[win_chan];
            end
        end
    end
    assign node_flag   = flag_q;
    assign trap_flag   = tflag_q;
    assign trap_active = tact_q;
endmodule
`default_nettype wire

// [test/iets_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module iets_cpu_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // service start seen by the core
    input wire logic svc_start,
    input wire iets_pkg::iets_svc_t svc_kind,
    input wire logic slow,
    // return from trap routine
    output logic trap_done
);
    logic [3:0] left_q;
    // a trap routine lasts one or five cycles; a nested start reloads
    always_ff @(posedge clk_sys)
    begin
        trap_done <= !reset && left_q == 4'h1;
        if (reset)
            left_q <= 4'h0;
        else if (svc_start && svc_kind == iets_pkg::SVC_TRAP)
            left_q <= slow ? 4'h5 : 4'h1;
        else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
    end
endmodule
`default_nettype wire

// [test/iets_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module iets_top_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // causes
    input wire logic jump_cache_en,
    input wire logic [iets_pkg::NODES-1:0] node_sw_set,
    input wire logic [iets_pkg::HW_TRAPS-1:0] hw_trap,
    // effects
    input wire logic svc_start,
    input wire iets_pkg::iets_svc_t svc_kind,
    input wire iets_pkg::iets_node_t svc_num,
    input wire iets_pkg::iets_lvl_t svc_level,
    input wire logic xfer_valid,
    input wire logic [iets_pkg::NODES-1:0] node_flag,
    input wire logic [iets_pkg::TRAPS-1:0] trap_flag,
    input wire logic [iets_pkg::TRAPS-1:0] trap_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // starts and stolen cycles are single pulses
    property p_start; svc_start |=> !svc_start; endproperty
    a_start: assert property (p_start)
        else $error("start too long");
    property p_xfer; xfer_valid |=> !xfer_valid; endproperty
    a_xfer: assert property (p_xfer)
        else $error("transfer too long");
    // with the jump cache on, the served node must already have been flagged 7 clocks before
    property p_lat; svc_start && svc_kind == iets_pkg::SVC_IRQ
        && jump_cache_en |-> (($past(node_flag, 7) >> svc_num) & 96'h1) != '0;
    endproperty
    a_lat: assert property (p_lat)
        else $error("start too early");
    // no interrupt start or stolen transfer runs while a trap was active
    property p_block; (xfer_valid || svc_start && svc_kind ==
        iets_pkg::SVC_IRQ) |-> $past(trap_active) == '0; endproperty
    a_block: assert property (p_block)
        else $error("irq in trap");
    property p_tlvl; svc_start && svc_kind == iets_pkg::SVC_TRAP |->
        svc_level == iets_pkg::TRAP_LVL && trap_flag[svc_num[2:0]]; endproperty
    a_tlvl: assert property (p_tlvl)
        else $error("trap flag or level");
    property p_tpre; svc_start && svc_kind == iets_pkg::SVC_TRAP |->
        ($past(trap_active) & ((8'h01 << svc_num[2:0]) - 8'h01)) == '0;
    endproperty
    a_tpre: assert property (p_tpre)
        else $error("trap preempted");
    property p_tflag; hw_trap != '0 |=>
        (trap_flag[5:0] & $past(hw_trap)) == $past(hw_trap); endproperty
    a_tflag: assert property (p_tflag)
        else $error("trap flag lost");
    property p_swset; node_sw_set != '0 |=>
        (node_flag & $past(node_sw_set)) == $past(node_sw_set); endproperty
    a_swset: assert property (p_swset)
        else $error("sw set lost");
endmodule
bind iets_top iets_top_props u_props (.*);
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic reset, jump_cache_en, sw_trap, trap_done, slow, svc_start;
    logic xfer_valid, xfer_word, ws, ai, bi;
    logic [3:0] cpu_level, src_sel, rtr_pin, svc_level;
    logic [2:0] esr_pin, esr_en, esr_map, xfer_chan;
    logic [6:0] sw_trap_num, svc_num;
    logic [95:0] periph_req, node_sw_set, node_sw_clr, node_en;
    logic [95:0] node_etc_en, node_flag;
    logic [383:0] node_prio;
    logic [287:0] node_chan;
    logic [7:0] ch_load, ch_word, ch_inc_src, ch_inc_dst, ch_cont;
    logic [7:0] ch_load_cnt, rtr_edge_sel, rtr_gate, trap_flag_clr;
    logic [7:0] trap_flag, trap_active;
    logic [23:0] ch_load_src, ch_load_dst, xfer_src, xfer_dst, s, d;
    logic [15:0] rtr_route, rtr_pat;
    logic [5:0] hw_trap;
    iets_pkg::iets_svc_t svc_kind;
    int errors = 0, n_compared = 0, cyc = 0, k, n, p;

    iets_top u_dut (.*);
    iets_cpu_model u_cpu (.*);

    always #20 clk_sys = ~clk_sys;
    // a lost start must not hang the run
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // bounded wait for a transfer (x) or a service start
    task automatic wt(bit x, output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys);
            #1 c++;
        end while ((x ? xfer_valid : svc_start) !== 1'b1 && c < 40);
    endtask
    task automatic setn(int i, logic [3:0] pr);
        node_en[i] <= 1'b1;
        node_prio[4*i +: 4] <= pr;
        node_sw_set[i] <= 1'b1;
        @(posedge clk_sys) node_sw_set <= '0;
    endtask
    task automatic clrt;
        trap_flag_clr <= 8'hFF;
        @(posedge clk_sys) trap_flag_clr <= '0;
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        {jump_cache_en, sw_trap, slow, cpu_level, src_sel, rtr_pin, esr_pin,
         esr_en, esr_map, sw_trap_num, periph_req, node_sw_set, node_sw_clr,
         node_en, node_etc_en, node_prio, node_chan, ch_load, ch_word,
         ch_inc_src, ch_inc_dst, ch_cont, ch_load_cnt, rtr_edge_sel, rtr_gate,
         trap_flag_clr, ch_load_src, ch_load_dst, rtr_route, rtr_pat,
         hw_trap} = '0;
        reset = 1'b1;
        void'($urandom(32'h32c1));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1 chk("reset", {node_flag, trap_flag, trap_active}, '0);
        // random nodes, both latencies
        repeat (5)
        begin
            n = $urandom_range(87);
            p = $urandom_range(15, 2);
            jump_cache_en <= 1'($urandom_range(1));
            cpu_level <= 4'(p - 1);
            setn(n, 4'(p));
            wt(0, k);
            chk("lat", k, jump_cache_en ? 7 : 11);
            chk("svc", {svc_kind, svc_num, svc_level, node_flag[n]},
                {iets_pkg::SVC_IRQ, 7'(n), 4'(p), 1'b0});
        end
        // equal level refused, higher node wins
        cpu_level <= 4'h5;
        setn(3, 4'h5);
        setn(4, 4'h9);
        wt(0, k);
        chk("pri", svc_num, 7'h04);
        wt(0, k);
        chk("refuse", {node_flag[3], svc_start}, 2'b10);
        cpu_level <= 4'h4;
        wt(0, k);
        chk("low", svc_num, 7'h03);
        $display("test nodes done");
        // every channel: two transfers, then the vector
        cpu_level <= 4'h0;
        for (int c = 0; c < 8; c++)
        begin
            n = 10 + c;
            s = 24'($urandom);
            d = 24'($urandom);
            {ws, ai, bi} = 3'($urandom);
            node_etc_en[n] <= 1'b1;
            node_chan[3*n +: 3] <= 3'(c);
            ch_word[c] <= ws;
            ch_inc_src[c] <= ai;
            ch_inc_dst[c] <= bi;
            {ch_load_src, ch_load_dst, ch_load_cnt} <= {s, d, 8'h02};
            ch_load[c] <= 1'b1;
            setn(n, 4'h3);
            ch_load <= '0;
            repeat (2)
            begin
                wt(1, k);
                chk("xfer", {xfer_chan, xfer_word, xfer_src, xfer_dst},
                    {3'(c), ws, s, d});
                s += ai ? (ws ? 24'h2 : 24'h1) : 24'h0;
                d += bi ? (ws ? 24'h2 : 24'h1) : 24'h0;
                periph_req[n] <= 1'b1;
                @(posedge clk_sys) periph_req[n] <= 1'b0;
            end
            wt(0, k);
            chk("vec", {svc_kind, svc_num}, {iets_pkg::SVC_IRQ, 7'(n)});
        end
        $display("test channels done");
        for (int i = 0; i < 6; i++)
        begin
            slow <= 1'($urandom_range(1));
            hw_trap[i] <= 1'b1;
            @(posedge clk_sys) hw_trap <= '0;
            wt(0, k);
            chk("trap", {svc_kind, svc_num, trap_flag[i], trap_active[i]},
                {iets_pkg::SVC_TRAP, 7'(i), 2'b11});
            repeat (8) @(posedge clk_sys);
            clrt();
            #1 chk("ret", {trap_flag, trap_active}, '0);
        end
        n = $urandom_range(127);
        sw_trap_num <= 7'(n);
        sw_trap <= 1'b1;
        @(posedge clk_sys) sw_trap <= 1'b0;
        wt(0, k);
        chk("sw", {svc_kind, svc_num}, {iets_pkg::SVC_SWTRAP, 7'(n)});
        $display("test traps done");
        // router: falling edge only, routed straight through to shared nodes
        {src_sel, rtr_route, rtr_gate, rtr_edge_sel} <= {4'hF, 16'h8421,
            8'h55, 8'hAA};
        for (int j = 0; j < 4; j++)
        begin
            rtr_pin[j] <= 1'b1;
            repeat (8) @(posedge clk_sys);
            #1 chk("rise", node_flag[88 + j], 1'b0);
            rtr_pin[j] <= 1'b0;
            repeat (8) @(posedge clk_sys);
            #1 chk("fall", node_flag[88 + j], 1'b1);
        end
        {esr_en, esr_map} <= {3'h7, 3'h2};
        for (int j = 0; j < 3; j++)
        begin
            esr_pin[j] <= 1'b1;
            repeat (12) @(posedge clk_sys);
            #1 chk("esr", trap_flag[7:6], j == 1 ? 2'b10 : 2'b01);
            clrt();
        end
        $display("test router done");
        summarize();
    end
endmodule
`default_nettype wire
